// ### hdl/pmm_div.sv
// programmable divider making one-cycle enable pulses
`timescale 1ns/1ps
module pmm_div #(
  parameter int W = 5
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_en,
  input wire logic [W-1:0] i_div,
  output logic o_tick
);
  logic [W-1:0] cnt_q;
  // a divide of 0 or 1 ticks every enabled cycle
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end
    else if (!i_en)
      o_tick <= 1'b0;
    else if (cnt_q + W'(1) >= i_div)
    begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule

// ### hdl/pmm_pkg.sv
// constants, modes and register map for the power mode manager
package pmm_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_LOCK = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL_REG = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_SLOW = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_DIVN = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_EMASK = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_SOURCE_PENDING_REG = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_EPEND = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STAT2 = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_SCRA = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_SCRB = 6'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATE = 6'h30;
  localparam logic [ADDR_W-1:0] OFF_FUNC = 6'h34;
  localparam logic [ADDR_W-1:0] OFF_GPIO = 6'h38;
  // clock control bits
  localparam int BIT_IDLE = 2;
  localparam int BIT_POFF = 3;
  // slow control bits
  localparam int SLOW_DIVIDER_FIELD_LSB = 0;
  localparam int BIT_SLOW = 4;
  localparam int BIT_MPLL_OFF = 5;
  // bus divider and status bits
  localparam int BIT_PDIV = 0;
  localparam int BIT_HDIV = 1;
  localparam int BIT_WAKE = 2;
  localparam int BIT_BATT = 24;
  localparam logic [11:0] LOCK_RST = 12'hfff;
  localparam int NIRQ = 24;
  localparam int NWAKE = 16;
  localparam int NSRC = 4;
  localparam int GPIO_W = 16;
  localparam int CLK_MHZ = 125;
  localparam int LOCK_US = 150;
  localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
  localparam int WAKE_RST_CNT = 65535;
  typedef enum logic [2:0] {
    PM_NORMAL, PM_IDLE_REQ, PM_IDLE, PM_OFF, PM_WAKE_RST
  } pmm_mode_t;
endpackage

// ### hdl/pmm_top.sv
// power mode manager: idle, slow, power-off sequencing and registers
`timescale 1ns/1ps
module pmm_top
  import pmm_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC,
  parameter int WAKE_CYCLES = WAKE_RST_CNT
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [NIRQ-1:0] i_external_irq_pins,
  input wire logic i_rtc_alarm,
  input wire logic i_other_irq,
  input wire logic i_battery_fault_n,
  input wire logic i_idle_ack,
  input wire logic [GPIO_W-1:0] i_func_out,
  output logic o_core_clk_en,
  output logic o_bus_clk_en,
  output logic o_periph_clk_en,
  output logic o_pll_use,
  output logic o_pll_power,
  output logic o_idle_req,
  output logic o_core_power_enable,
  output logic o_core_reset,
  output logic [GPIO_W-1:0] o_pin_out
);
  logic [23:0] irq_s1_q, irq_s2_q;
  logic [1:0] alarm_s_q, batt_s_q, ack_s_q;
  logic [11:0] lock_q;
  logic [31:0] clock_control_reg_q, scra_q, scrb_q;
  logic [5:0] slow_q;
  logic [1:0] divn_q;
  logic [NIRQ-1:0] emask_q, epend_q, func_q;
  logic [NSRC:0] source_pending_reg_q;
  logic [GPIO_W-1:0] gpio_q, hold_q;
  logic wake_flag_q, locking_q, slow_clk_q;
  logic [31:0] lock_cnt_q, wake_cnt_q;
  pmm_mode_t mode_q;
  logic wr, rd_ok, core_tick, bus_tick, per_tick, half_b_q, half_p_q;
  logic [4:0] slow_div;
  logic [NWAKE-1:0] wake_src;
  logic wake_ev, any_irq, batt_ok;

  // two-stage synchronisers for pin inputs; i_other_irq is used unsynchronised
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      alarm_s_q <= '0;
      batt_s_q <= 2'b11;
      ack_s_q <= '0;
    end
    else
    begin
      irq_s1_q <= i_external_irq_pins;
      irq_s2_q <= irq_s1_q;
      alarm_s_q <= {alarm_s_q[0], i_rtc_alarm};
      batt_s_q <= {batt_s_q[0], i_battery_fault_n};
      ack_s_q <= {ack_s_q[0], i_idle_ack};
    end
  end

  assign batt_ok = batt_s_q[1];
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  // only pins set to interrupt function may wake
  assign wake_src = irq_s2_q[NWAKE-1:0] & func_q[NWAKE-1:0];
  // battery fault masks all wake sources
  assign wake_ev = batt_ok && ((|wake_src) || alarm_s_q[1]);
  assign any_irq = (|(irq_s2_q & func_q)) || alarm_s_q[1] || i_other_irq;

  // wishbone ack: one wait-free cycle, dropped after one
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_wb_dat <= '0;
    else
    begin
      case (i_wb_adr)
        OFF_LOCK: o_wb_dat <= {20'h0, lock_q};
        OFF_CLOCK_CONTROL_REG: o_wb_dat <= clock_control_reg_q;
        OFF_SLOW: o_wb_dat <= {26'h0, slow_q};
        OFF_DIVN: o_wb_dat <= {30'h0, divn_q};
        OFF_EMASK: o_wb_dat <= {8'h0, emask_q};
        OFF_SOURCE_PENDING_REG: o_wb_dat <= {27'h0, source_pending_reg_q};
        OFF_EPEND: o_wb_dat <= {8'h0, epend_q};
        OFF_STAT2: o_wb_dat <= {29'h0, wake_flag_q, 2'h0};
        OFF_SCRA: o_wb_dat <= scra_q;
        OFF_SCRB: o_wb_dat <= scrb_q;
        OFF_STATE: o_wb_dat <= {28'h0, locking_q, 3'(mode_q)};
        OFF_FUNC: o_wb_dat <= {8'h0, func_q};
        OFF_GPIO: o_wb_dat <= {16'h0, gpio_q};
        default: o_wb_dat <= '0;
      endcase
    end
  end

  // plain config registers; idle and power-off bits self-clear
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      lock_q <= LOCK_RST;
      clock_control_reg_q <= '0;
      slow_q <= '0;
      divn_q <= '0;
      emask_q <= '1;
      func_q <= '0;
      gpio_q <= '0;
    end
    else
    begin
      if (wr && i_wb_adr == OFF_LOCK)
        lock_q <= i_wb_dat[11:0];
      if (wr && i_wb_adr == OFF_CLOCK_CONTROL_REG)
        clock_control_reg_q <= i_wb_dat;
      else if (mode_q != PM_NORMAL)
      begin
        clock_control_reg_q[BIT_IDLE] <= 1'b0;
        clock_control_reg_q[BIT_POFF] <= 1'b0;
      end
      if (wr && i_wb_adr == OFF_SLOW)
        slow_q <= i_wb_dat[5:0];
      if (wr && i_wb_adr == OFF_DIVN)
        divn_q <= i_wb_dat[1:0];
      if (wr && i_wb_adr == OFF_EMASK)
        emask_q <= i_wb_dat[NIRQ-1:0];
      if (wr && i_wb_adr == OFF_FUNC)
        func_q <= i_wb_dat[NIRQ-1:0];
      if (wr && i_wb_adr == OFF_GPIO)
        gpio_q <= i_wb_dat[GPIO_W-1:0];
    end
  end

  // scratch registers sit in the always-on domain
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      scra_q <= '0;
      scrb_q <= '0;
    end
    else
    begin
      if (wr && i_wb_adr == OFF_SCRA)
        scra_q <= i_wb_dat;
      if (wr && i_wb_adr == OFF_SCRB)
        scrb_q <= i_wb_dat;
    end
  end

  // mode sequencer
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      mode_q <= PM_NORMAL;
    else
    begin
      case (mode_q)
        PM_NORMAL:
          if (clock_control_reg_q[BIT_POFF])
            mode_q <= PM_OFF;
          else if (clock_control_reg_q[BIT_IDLE])
            mode_q <= PM_IDLE_REQ;
        PM_IDLE_REQ:
          if (any_irq)
            mode_q <= PM_NORMAL;
          else if (ack_s_q[1])
            mode_q <= PM_IDLE;
        PM_IDLE:
          if (any_irq)
            mode_q <= PM_NORMAL;
        PM_OFF:
          if (wake_ev)
            mode_q <= PM_WAKE_RST;
        PM_WAKE_RST:
          if (wake_cnt_q >= 32'(WAKE_CYCLES - 1))
            mode_q <= PM_NORMAL;
        default: mode_q <= PM_NORMAL;
      endcase
    end
  end

  // wake reset duration counter
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      wake_cnt_q <= '0;
    else if (mode_q == PM_WAKE_RST)
      wake_cnt_q <= wake_cnt_q + 32'd1;
    else
      wake_cnt_q <= '0;
  end

  // wake cause flag, set wins over clear by write-one
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      wake_flag_q <= 1'b0;
    else if (mode_q == PM_OFF && wake_ev)
      wake_flag_q <= 1'b1;
    else if (wr && i_wb_adr == OFF_STAT2 && i_wb_dat[BIT_WAKE])
      wake_flag_q <= 1'b0;
  end

  // pending bits: unmasked sources latch, write-one clears, set wins
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      source_pending_reg_q <= '0;
      epend_q <= '0;
    end
    else
    begin
      if (wr && i_wb_adr == OFF_SOURCE_PENDING_REG)
        source_pending_reg_q <= source_pending_reg_q & ~i_wb_dat[NSRC:0];
      if (wr && i_wb_adr == OFF_EPEND)
        epend_q <= epend_q & ~i_wb_dat[NIRQ-1:0];
      if (mode_q == PM_OFF && wake_ev)
      begin
        // masked sources still wake and set the wake flag but no pending bit
        source_pending_reg_q[NSRC-1:0] <= source_pending_reg_q[NSRC-1:0] |
          (wake_src[NSRC-1:0] & ~emask_q[NSRC-1:0]);
        epend_q[NWAKE-1:NSRC] <= epend_q[NWAKE-1:NSRC] |
          (wake_src[NWAKE-1:NSRC] & ~emask_q[NWAKE-1:NSRC]);
      end
      if (mode_q == PM_OFF && !batt_ok)
        source_pending_reg_q[NSRC] <= 1'b1;
    end
  end

  // pll lock interval after pll re-enable
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      locking_q <= 1'b0;
      lock_cnt_q <= '0;
    end
    else if (wr && i_wb_adr == OFF_SLOW && slow_q[BIT_MPLL_OFF]
             && !i_wb_dat[BIT_MPLL_OFF])
    begin
      locking_q <= 1'b1;
      lock_cnt_q <= '0;
    end
    else if (locking_q)
    begin
      lock_cnt_q <= lock_cnt_q + 32'd1;
      // register count, but never under the nominal time
      if (lock_cnt_q >= 32'(LOCK_CYCLES - 1) &&
          lock_cnt_q >= 32'(lock_q))
        locking_q <= 1'b0;
    end
  end

  // clock source select; hardware turns pll power off in power-off only
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      slow_clk_q <= 1'b0;
      o_pll_use <= 1'b1;
      o_pll_power <= 1'b1;
    end
    else
    begin
      o_pll_power <= !slow_q[BIT_MPLL_OFF] && mode_q != PM_OFF;
      // slow set or lock running keeps slow clock
      slow_clk_q <= slow_q[BIT_SLOW] || locking_q;
      o_pll_use <= !(slow_q[BIT_SLOW] || locking_q);
    end
  end

  // slow divider: code 0 is 1, else twice the code
  assign slow_div = (slow_q[2:0] == 3'h0) ? 5'd1 :
                    {1'b0, slow_q[2:0], 1'b0};

  pmm_div #(.W(5)) u_core_div (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_en(slow_clk_q),
    .i_div(slow_div),
    .o_tick(core_tick)
  );

  // halving stages for bus and peripheral enables
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      half_b_q <= 1'b0;
      half_p_q <= 1'b0;
    end
    else
    begin
      if (core_tick)
        half_b_q <= !half_b_q;
      if (bus_tick)
        half_p_q <= !half_p_q;
    end
  end

  assign bus_tick = core_tick && (!divn_q[BIT_HDIV] || half_b_q);
  assign per_tick = bus_tick && (!divn_q[BIT_PDIV] || half_p_q);

  // clock enables; idle stops only core, bus and peripheral untouched
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_core_clk_en <= 1'b1;
      o_bus_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
    end
    else
    begin
      o_core_clk_en <= (slow_clk_q ? core_tick : 1'b1) &&
                       mode_q != PM_IDLE && mode_q != PM_OFF;
      o_bus_clk_en <= (slow_clk_q ? bus_tick : 1'b1) &&
                      mode_q != PM_OFF;
      o_periph_clk_en <= (slow_clk_q ? per_tick : 1'b1) &&
                         mode_q != PM_OFF;
    end
  end

  // power, reset and pin hold outputs
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_core_power_enable <= 1'b1;
      o_core_reset <= 1'b0;
      o_idle_req <= 1'b0;
      hold_q <= '0;
      o_pin_out <= '0;
    end
    else
    begin
      o_core_power_enable <= mode_q != PM_OFF;
      o_core_reset <= mode_q == PM_WAKE_RST;
      o_idle_req <= mode_q == PM_IDLE_REQ;
      if (mode_q != PM_OFF)
        hold_q <= i_func_out;
      // in power-off gpio pins drive data value, function pins hold level; otherwise all pins follow i_func_out
      o_pin_out <= (mode_q == PM_OFF) ?
        ((gpio_q & ~func_q[GPIO_W-1:0]) | (hold_q & func_q[GPIO_W-1:0]))
        : i_func_out;
    end
  end

  sequence s_off_wake;
    mode_q == PM_OFF && wake_ev;
  endsequence

  power_off_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    mode_q == PM_OFF |=> !o_core_power_enable)
    else $error("power stays on in power-off");
  wake_reset_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_off_wake |=> ##1 o_core_reset[*8])
    else $error("wake reset too short");
  batt_mask_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    mode_q == PM_OFF && !batt_ok |=> mode_q == PM_OFF)
    else $error("woke with battery fault");
  wake_flag_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_off_wake |=> wake_flag_q)
    else $error("wake cause not recorded");
  idle_ack_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    mode_q == PM_IDLE_REQ && !ack_s_q[1] |=> mode_q != PM_IDLE)
    else $error("idle without ack");
  idle_core_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    mode_q == PM_IDLE ##1 mode_q == PM_IDLE |-> !o_core_clk_en)
    else $error("core clock runs in idle");
  lock_slow_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    locking_q |=> !o_pll_use)
    else $error("pll used during lock");
  slow_now_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    slow_q[BIT_SLOW] |=> !o_pll_use)
    else $error("slow not taken at once");
  masked_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_off_wake and (emask_q[0] && !source_pending_reg_q[0]) |=> !source_pending_reg_q[0])
    else $error("masked source set pending");
endmodule

// ### tb/pmm_partner.sv
// far-side model: wake sources, idle ack and core regulator
`timescale 1ns/1ps
module pmm_partner (
  input wire logic i_core_clk,
  input wire logic i_idle_req,
  input wire logic i_core_power_enable,
  input wire logic [23:0] i_irq_cmd,
  input wire logic i_batt_low,
  output logic [23:0] o_external_irq_pins,
  output logic o_battery_fault_n,
  output logic o_idle_ack,
  output logic o_supply_on
);
  logic [1:0] ack_q = 2'h0;
  // wrapper acks two cycles late, so entry must wait for it
  always_ff @(posedge i_core_clk)
  begin
    ack_q <= {ack_q[0], i_idle_req};
  end
  assign o_idle_ack = ack_q[1];
  // fault pin is low only while the battery is weak
  assign o_battery_fault_n = !i_batt_low;
  assign o_external_irq_pins = i_irq_cmd;
  // regulator output simply follows its enable
  assign o_supply_on = i_core_power_enable;
endmodule

// ### tb/tb.sv
// self-checking bench for the power mode manager
`timescale 1ns/1ps
module tb
  import pmm_pkg::*;
();
  localparam int LK = 20;
  localparam int WK = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic [23:0] irq = 24'h0;
  logic [23:0] pins;
  logic alarm = 1'b0;
  logic oth = 1'b0;
  logic batt = 1'b0;
  logic [15:0] fo = 16'h3c5a;
  logic [15:0] pout;
  logic ack, bfn, iack, sup, cen, ben, pen, puse, ppow, ireq, pwe, crst;
  int errors = 0;
  int compares = 0;
  int nc, nb, np, n;
  // 8 ns period
  always #4 clk = ~clk;
  pmm_top #(.LOCK_CYCLES(LK), .WAKE_CYCLES(WK)) pmm_top_i (
    .i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_external_irq_pins(pins),
    .i_rtc_alarm(alarm), .i_other_irq(oth), .i_battery_fault_n(bfn),
    .i_idle_ack(iack), .i_func_out(fo), .o_core_clk_en(cen),
    .o_bus_clk_en(ben), .o_periph_clk_en(pen), .o_pll_use(puse),
    .o_pll_power(ppow), .o_idle_req(ireq), .o_core_power_enable(pwe),
    .o_core_reset(crst), .o_pin_out(pout));
  pmm_partner pmm_partner_i (
    .i_core_clk(clk), .i_idle_req(ireq), .i_core_power_enable(pwe),
    .i_irq_cmd(irq), .i_batt_low(batt), .o_external_irq_pins(pins),
    .o_battery_fault_n(bfn), .o_idle_ack(iack), .o_supply_on(sup));
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, m, g, e);
    end
  endtask
  task automatic hang(input string m);
    errors++;
    $display("CHECK FAILED %0t %s timed out", $time, m);
    print_verdict;
  endtask
  function automatic logic near(input int a, e);
    return a >= e - 1 && a <= e + 1;
  endfunction
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      if (k++ == 20)
        hang("ack");
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return cen;
      1: return crst;
      2: return puse;
      default: return pwe;
    endcase
  endfunction
  // bounded wait on one output
  task automatic wt(input int k, input logic v, input int b);
    int i;
    i = 0;
    while (sig(k) !== v)
    begin
      if (i++ == b)
        hang("wait");
      @(posedge clk);
    end
  endtask
  task automatic cnt(input int t);
    nc = 0;
    nb = 0;
    np = 0;
    repeat (t)
    begin
      @(posedge clk);
      nc += cen;
      nb += ben;
      np += pen;
    end
  endtask
  task automatic pulse(input logic [23:0] m);
    irq <= m;
    repeat (6) @(posedge clk);
    irq <= 24'h0;
    repeat (12) @(posedge clk);
  endtask
  task automatic t_reset;
    chk(pwe, 1'b1, "power at reset");
    chk(crst, 1'b0, "core reset idle");
    wb(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, OFF_LOCK, 32'h0);
  endtask
  // idle entry, then exit by source s
  task automatic t_idle(input int s);
    wb(1'b1, OFF_CLOCK_CONTROL_REG, 32'h4);
    wt(0, 1'b0, 20);
    chk(iack, 1'b1, "ack before idle");
    chk(ben, 1'b1, "bus clock runs");
    repeat (4) @(posedge clk);
    chk({cen, ben}, 2'b01, "core stays off");
    oth <= s == 0;
    alarm <= s == 1;
    irq <= s == 2 ? 24'h800000 : 24'h0;
    wt(0, 1'b1, 8);
    oth <= 1'b0;
    alarm <= 1'b0;
    irq <= 24'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_slow;
    for (int c = 0; c < 8; c++)
    begin
      wb(1'b1, OFF_SLOW, 32'h10 | c);
      cnt(168);
      chk(near(nc, c ? 168 / (2 * c) : 168), 1'b1, "divide");
      chk(nb, nc, "bus equals core");
      chk(puse, 1'b0, "pll bypassed");
    end
    wb(1'b1, OFF_SLOW, 32'h11);
    wb(1'b1, OFF_DIVN, 32'h3);
    cnt(168);
    chk({near(nb, 42), near(np, 21)}, 2'b11, "halves");
    wb(1'b1, OFF_DIVN, 32'h0);
    wb(1'b1, OFF_SLOW, 32'h0);
    wt(2, 1'b1, 3);
  endtask
  task automatic t_lock;
    wb(1'b1, OFF_SLOW, 32'h11);
    wb(1'b1, OFF_SLOW, 32'h31);
    repeat (2) @(posedge clk);
    chk(ppow, 1'b0, "pll off");
    wb(1'b1, OFF_SLOW, 32'h01);
    n = 0;
    nc = 0;
    while (puse !== 1'b1 && n < LK + 10)
    begin
      @(posedge clk);
      n++;
      nc += cen;
    end
    chk(ppow, 1'b1, "pll on");
    chk(n >= LK - 2 && n <= LK + 4, 1'b1, "lock length");
    chk(near(nc, n / 2), 1'b1, "slow during lock");
    wb(1'b1, OFF_SLOW, 32'h0);
  endtask
  // power-off, refused wakes, then a wake by pin p
  task automatic t_poff(input int p, input logic [31:0] so, eo);
    fo <= 16'h3c5a;
    wb(1'b1, OFF_CLOCK_CONTROL_REG, 32'h8);
    wt(3, 1'b0, 5);
    fo <= 16'hc3a5;
    batt <= 1'b1;
    pulse(24'h1 << p);
    batt <= 1'b0;
    pulse(24'h100200);
    chk({crst, pwe}, 2'b00, "stays off");
    chk(pout, 16'ha55a, "pins held");
    irq <= 24'h1 << p;
    wt(1, 1'b1, 12);
    irq <= 24'h0;
    for (n = 0; crst === 1'b1 && n < 99; n++)
      @(posedge clk);
    chk(n, WK, "wake reset length");
    chk(pwe, 1'b1, "power back");
    wb(1'b0, OFF_STAT2, 32'h0);
    chk(q[2], 1'b1, "wake flag");
    wb(1'b0, OFF_SCRA, 32'h0);
    chk(q, 32'h5a5a1234, "scratch kept");
    wb(1'b0, OFF_SOURCE_PENDING_REG, 32'h0);
    chk(q & 32'h1f, so, "source pend");
    wb(1'b0, OFF_EPEND, 32'h0);
    chk(q & 32'hffff, eo, "ext pend");
    pulse(24'h1 << p);
    chk({crst, pwe}, 2'b01, "no second wake");
    wb(1'b1, OFF_STAT2, 32'h4);
    wb(1'b1, OFF_SOURCE_PENDING_REG, 32'h1f);
    wb(1'b1, OFF_EPEND, 32'hffff);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    // pin 23 must be in interrupt function to end idle
    wb(1'b1, OFF_FUNC, 32'h800000);
    for (int s = 0; s < 3; s++)
      t_idle(s);
    t_slow;
    t_lock;
    wb(1'b1, OFF_FUNC, 32'hff);
    wb(1'b1, OFF_GPIO, 32'ha5c3);
    wb(1'b1, OFF_EMASK, 32'hffffffbd);
    wb(1'b1, OFF_SCRA, 32'h5a5a1234);
    t_poff(1, 32'h12, 32'h0);
    t_poff(6, 32'h10, 32'h40);
    t_poff(2, 32'h10, 32'h0);
    print_verdict;
  end
endmodule
